// [psap_pkg.sv]
package psap_pkg;

    // Word geometry: each byte lane carries eight data bits and one parity bit
    localparam int PSAP_LANE_DATA_W = 8;
    localparam int PSAP_LANE_W      = 9;
    localparam int PSAP_LANES       = 4;
    localparam int PSAP_ADDR_W      = 10;

    // Burst counter covers the two lowest address bits
    localparam int         PSAP_BURST_W     = 2;
    localparam logic [1:0] PSAP_BURST_START = 2'h0;
    localparam logic [1:0] PSAP_BURST_STEP  = 2'h1;

    // Write data buffer between the bus and the storage core
    localparam int PSAP_FIFO_DEPTH = 8;

    // Reset values of the two input synchronisers
    localparam logic PSAP_SLEEP_RESET = 1'b0;
    localparam logic PSAP_MODE_RESET  = 1'b1;

    // Sleep sequencing, Gray coded along enter and exit
    typedef enum logic [1:0] {
        PSAP_AWAKE  = 2'h0,
        PSAP_DOZE   = 2'h1,
        PSAP_ASLEEP = 2'h3,
        PSAP_WAKE   = 2'h2
    } psap_sleep_type;

endpackage : psap_pkg

// [psap_stream_if.sv]
`timescale 1ns/10ps

interface psap_stream_if #(
    parameter int WIDTH = 8
);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport source (output valid, output data, input  ready);
    modport sink   (input  valid, input  data, output ready);
endinterface : psap_stream_if

// [psap_fifo.sv]
`timescale 1ns/10ps

module psap_fifo
    import psap_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = PSAP_FIFO_DEPTH
) (
    input  wire logic      clock,
    input  wire logic      nrst,
    psap_stream_if.sink    fill,
    psap_stream_if.source  drain
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [PW-1:0]    rd_ptr;
        logic [PW-1:0]    wr_ptr;
        logic [CW-1:0]    count;
        logic             head_valid;
        logic [WIDTH-1:0] head_data;
    } psap_fifo_state_type;

    psap_fifo_state_type st_reg;
    psap_fifo_state_type st_next;
    logic [WIDTH-1:0]    body [DEPTH];
    logic                push;
    logic                pop;
    logic                head_load;
    logic                body_write;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : ptr_inc

    // Read data always leaves from the head register
    assign fill.ready  = (st_reg.count != CW'(DEPTH));
    assign drain.valid = st_reg.head_valid;
    assign drain.data  = st_reg.head_data;
    assign push        = fill.valid & fill.ready;
    assign pop         = st_reg.head_valid & drain.ready;
    assign head_load   = ~st_reg.head_valid | pop;
    assign body_write  = push & ~(head_load & (st_reg.count == '0));

    always_comb begin
        st_next = st_reg;
        if (head_load) begin
            if (st_reg.count != '0) begin
                st_next.head_data  = body[st_reg.rd_ptr];
                st_next.head_valid = 1'b1;
                st_next.rd_ptr     = ptr_inc(st_reg.rd_ptr);
            end else if (push) begin
                st_next.head_data  = fill.data;
                st_next.head_valid = 1'b1;
            end else begin
                st_next.head_valid = 1'b0;
            end
        end
        if (body_write) begin
            st_next.wr_ptr = ptr_inc(st_reg.wr_ptr);
        end
        case ({body_write, head_load && (st_reg.count != '0)})
            2'b10:   st_next.count = st_reg.count + CW'(1);
            2'b01:   st_next.count = st_reg.count - CW'(1);
            default: st_next.count = st_reg.count;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge clock) begin
        if (body_write) begin
            body[st_reg.wr_ptr] <= fill.data;
        end
    end

endmodule : psap_fifo

// [psap_access_port.sv]
`timescale 1ns/10ps

module psap_access_port
    import psap_pkg::*;
#(
    parameter int ADDR_W     = PSAP_ADDR_W,
    parameter int LANES      = PSAP_LANES,
    parameter int FIFO_DEPTH = PSAP_FIFO_DEPTH
) (
    input  wire logic                          clock,
    input  wire logic                          nrst,
    input  wire logic                          clock_qualifier_n,
    input  wire logic                          chip_select_first_n,
    input  wire logic                          chip_select_second,
    input  wire logic                          chip_select_third_n,
    input  wire logic                          advance_or_load_n,
    input  wire logic                          write_select_n,
    input  wire logic [LANES-1:0]              byte_lane_write_n,
    input  wire logic                          output_enable_n,
    input  wire logic [ADDR_W-1:0]             address,
    input  wire logic                          burst_order_strap,
    input  wire logic                          sleep_request,
    input  wire logic [LANES*PSAP_LANE_DATA_W-1:0] data_lines_in,
    input  wire logic [LANES-1:0]              parity_data_lines_in,
    output logic [LANES*PSAP_LANE_DATA_W-1:0]  data_lines_out,
    output logic [LANES-1:0]                   parity_data_lines_out,
    output logic                               data_lines_oe,
    output logic                               write_buffer_ready
);
    localparam int WORD_W = LANES * PSAP_LANE_W;
    localparam int DATA_W = LANES * PSAP_LANE_DATA_W;
    localparam int DEPTH  = 1 << ADDR_W;
    localparam int FIFO_W = ADDR_W + LANES + WORD_W;

    typedef struct packed {
        logic                    sleep_meta;
        logic                    sleep_sync;
        logic                    mode_meta;
        logic                    mode_sync;
        psap_sleep_type          sleep_state;
        logic                    last_valid;
        logic                    last_wr;
        logic [ADDR_W-1:0]       base_addr;
        logic [PSAP_BURST_W-1:0] burst_cnt;
        logic                    s1_valid;
        logic                    s1_wr;
        logic [ADDR_W-1:0]       s1_addr;
        logic [LANES-1:0]        s1_bw_n;
        logic                    s2_valid;
        logic [ADDR_W-1:0]       s2_addr;
        logic [LANES-1:0]        s2_bw_n;
        logic                    drive;
        logic [WORD_W-1:0]       rd_data;
        logic                    buf_ready;
    } psap_state_type;

    psap_state_type    st_reg;
    psap_state_type    st_next;
    logic [WORD_W-1:0] core_mem [DEPTH];
    logic [WORD_W-1:0] core_rd;
    logic [WORD_W-1:0] bus_word;
    logic [ADDR_W-1:0] head_addr;
    logic [LANES-1:0]  head_bw_n;
    logic [WORD_W-1:0] head_word;
    logic              commit;

    psap_stream_if #(.WIDTH(FIFO_W)) wbuf_fill ();
    psap_stream_if #(.WIDTH(FIFO_W)) wbuf_drain ();

    function automatic logic [WORD_W-1:0] merge_lanes(
        input logic [WORD_W-1:0] old_word,
        input logic [WORD_W-1:0] new_word,
        input logic [LANES-1:0]  bw_n
    );
        logic [WORD_W-1:0] w;
        w = old_word;
        for (int i = 0; i < LANES; i++) begin
            if (!bw_n[i]) begin
                w[i*PSAP_LANE_W +: PSAP_LANE_W] =
                    new_word[i*PSAP_LANE_W +: PSAP_LANE_W];
            end
        end
        merge_lanes = w;
    endfunction : merge_lanes

    function automatic logic [ADDR_W-1:0] burst_addr(
        input logic [ADDR_W-1:0]       base,
        input logic [PSAP_BURST_W-1:0] cnt,
        input logic                    interleaved
    );
        logic [PSAP_BURST_W-1:0] low;
        low = interleaved ? (base[PSAP_BURST_W-1:0] ^ cnt)
                          : (base[PSAP_BURST_W-1:0] + cnt);
        burst_addr = {base[ADDR_W-1:PSAP_BURST_W], low};
    endfunction : burst_addr

    // Each lane stored as parity above its eight data bits
    always_comb begin
        bus_word = '0;
        for (int i = 0; i < LANES; i++) begin
            bus_word[i*PSAP_LANE_W +: PSAP_LANE_W] = {
                parity_data_lines_in[i],
                data_lines_in[i*PSAP_LANE_DATA_W +: PSAP_LANE_DATA_W]};
        end
    end

    assign {head_addr, head_bw_n, head_word} = wbuf_drain.data;
    assign core_rd = core_mem[st_reg.s1_addr];

    // Stored writes retire only outside deep sleep
    assign wbuf_drain.ready = (st_reg.sleep_state != PSAP_ASLEEP);
    assign commit           = wbuf_drain.valid & wbuf_drain.ready;

    psap_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wbuf (
        .clock (clock),
        .nrst  (nrst),
        .fill  (wbuf_fill),
        .drain (wbuf_drain)
    );

    always_comb begin
        logic                    awake;
        logic                    fire;
        logic                    chip_on;
        logic                    op_valid;
        logic                    op_wr;
        logic [LANES-1:0]        op_bw_n;
        logic [WORD_W-1:0]       fwd;
        awake    = 1'b0;
        fire     = 1'b0;
        chip_on  = 1'b0;
        op_valid = 1'b0;
        op_wr    = 1'b0;
        op_bw_n  = '1;
        fwd      = '0;
        st_next  = st_reg;

        // Asynchronous pins pass two flops; an idle sleep pin reads low
        st_next.sleep_meta = sleep_request;
        st_next.sleep_sync = st_reg.sleep_meta;
        st_next.mode_meta  = burst_order_strap;
        st_next.mode_sync  = st_reg.mode_meta;
        st_next.buf_ready  = wbuf_fill.ready;

        // Two cycles into and out of sleep; exit waits for stored writes
        case (st_reg.sleep_state)
            PSAP_AWAKE: begin
                if (st_reg.sleep_sync) begin
                    st_next.sleep_state = PSAP_DOZE;
                end
            end
            PSAP_DOZE: begin
                st_next.sleep_state = st_reg.sleep_sync ? PSAP_ASLEEP
                                                        : PSAP_AWAKE;
            end
            PSAP_ASLEEP: begin
                if (!st_reg.sleep_sync) begin
                    st_next.sleep_state = PSAP_WAKE;
                end
            end
            PSAP_WAKE: begin
                if (st_reg.sleep_sync) begin
                    st_next.sleep_state = PSAP_ASLEEP;
                end else if (!wbuf_drain.valid) begin
                    st_next.sleep_state = PSAP_AWAKE;
                end
            end
            default: begin
                st_next.sleep_state = PSAP_AWAKE;
            end
        endcase

        awake = (st_reg.sleep_state == PSAP_AWAKE);
        // A full write buffer stalls the pipeline like a masked edge when the second stage holds a write
        fire  = ~clock_qualifier_n & awake &
                (~st_reg.s2_valid | wbuf_fill.ready);

        if (fire) begin
            chip_on = ~chip_select_first_n & chip_select_second &
                      ~chip_select_third_n;
            op_bw_n = byte_lane_write_n;
            if (!advance_or_load_n) begin
                op_valid          = chip_on;
                op_wr             = ~write_select_n;
                st_next.base_addr = address;
                st_next.burst_cnt = PSAP_BURST_START;
            end else begin
                // Selects and write select ignored; after a deselect
                // the master must reload, so advancing stays deselected
                op_valid          = st_reg.last_valid;
                op_wr             = st_reg.last_wr;
                st_next.burst_cnt = st_reg.burst_cnt + PSAP_BURST_STEP;
            end
            st_next.last_valid = op_valid;
            st_next.last_wr    = op_wr;
            st_next.s1_valid   = op_valid;
            st_next.s1_wr      = op_wr;
            st_next.s1_bw_n    = op_bw_n;
            st_next.s1_addr    = burst_addr(st_next.base_addr,
                                            st_next.burst_cnt,
                                            st_reg.mode_sync);

            // Second stage: deselects and writes tri-state alike
            st_next.drive = st_reg.s1_valid & ~st_reg.s1_wr;
            if (st_reg.s1_valid && !st_reg.s1_wr) begin
                // Forward writes not yet in the core, newest last
                fwd = core_rd;
                if (wbuf_drain.valid && head_addr == st_reg.s1_addr) begin
                    fwd = merge_lanes(fwd, head_word, head_bw_n);
                end
                if (st_reg.s2_valid && st_reg.s2_addr == st_reg.s1_addr) begin
                    fwd = merge_lanes(fwd, bus_word, st_reg.s2_bw_n);
                end
                st_next.rd_data = fwd;
            end
            st_next.s2_valid = st_reg.s1_valid & st_reg.s1_wr;
            st_next.s2_addr  = st_reg.s1_addr;
            st_next.s2_bw_n  = st_reg.s1_bw_n;
        end else if (!awake) begin
            st_next.drive = 1'b0;
        end

        // Pending accesses are dropped once asleep
        if (st_reg.sleep_state == PSAP_ASLEEP) begin
            st_next.s1_valid   = 1'b0;
            st_next.s2_valid   = 1'b0;
            st_next.last_valid = 1'b0;
        end

        // Write data taken from the bus the edge after tri-state
        wbuf_fill.valid = fire & st_reg.s2_valid;
        wbuf_fill.data  = {st_reg.s2_addr, st_reg.s2_bw_n, bus_word};
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_reg             <= '0;
            st_reg.sleep_meta  <= PSAP_SLEEP_RESET;
            st_reg.sleep_sync  <= PSAP_SLEEP_RESET;
            st_reg.mode_meta   <= PSAP_MODE_RESET;
            st_reg.mode_sync   <= PSAP_MODE_RESET;
            st_reg.sleep_state <= PSAP_AWAKE;
            st_reg.s1_bw_n     <= '1;
            st_reg.s2_bw_n     <= '1;
        end else begin
            st_reg <= st_next;
        end
    end

    // Storage core has no reset; the buffer retires writes on its own
    always_ff @(posedge clock) begin
        if (commit) begin
            for (int i = 0; i < LANES; i++) begin
                if (!head_bw_n[i]) begin
                    core_mem[head_addr][i*PSAP_LANE_W +: PSAP_LANE_W] <=
                        head_word[i*PSAP_LANE_W +: PSAP_LANE_W];
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            data_lines_out[i*PSAP_LANE_DATA_W +: PSAP_LANE_DATA_W] =
                st_reg.rd_data[i*PSAP_LANE_W +: PSAP_LANE_DATA_W];
            parity_data_lines_out[i] =
                st_reg.rd_data[i*PSAP_LANE_W + PSAP_LANE_DATA_W];
        end
    end

    // Output enable gates the drivers without waiting for a clock
    assign data_lines_oe      = st_reg.drive & ~output_enable_n;
    assign write_buffer_ready = st_reg.buf_ready;

endmodule : psap_access_port

// [psap_access_port_props.sv]
`timescale 1ns/10ps

module psap_access_port_props
    import psap_pkg::*;
#(
    parameter int LANES = PSAP_LANES
) (
    input wire logic                              clock,
    input wire logic                              nrst,
    input wire logic                              clock_qualifier_n,
    input wire logic                              chip_select_first_n,
    input wire logic                              chip_select_second,
    input wire logic                              chip_select_third_n,
    input wire logic                              advance_or_load_n,
    input wire logic                              write_select_n,
    input wire logic                              output_enable_n,
    input wire logic                              sleep_request,
    input wire logic [LANES*PSAP_LANE_DATA_W-1:0] data_lines_out,
    input wire logic [LANES-1:0]                  parity_data_lines_out,
    input wire logic                              data_lines_oe
);
    logic       sel_on;
    logic       load_q;
    logic       awake;
    logic [4:0] calm_reg;

    assign sel_on = !chip_select_first_n && chip_select_second
                    && !chip_select_third_n;
    assign load_q = !clock_qualifier_n && !advance_or_load_n;
    assign awake  = calm_reg == 5'h1F;

    // Sleep sequencing lags the pin, so the pipeline is trusted once settled
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            calm_reg <= 5'h1F;
        else if (sleep_request)
            calm_reg <= 5'h00;
        else if (!awake)
            calm_reg <= calm_reg + 5'h01;
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    property p_oe_gate;
        output_enable_n |-> !data_lines_oe;
    endproperty
    a_oe_gate: assert property (p_oe_gate)
        else $error("drivers on while output enable is off");

    property p_stall_hold;
        clock_qualifier_n && awake |=>
            $stable(data_lines_out) && $stable(parity_data_lines_out);
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("read data moved on an ignored edge");

    property p_stall_oe;
        clock_qualifier_n && awake ##1 $stable(output_enable_n)
            |-> $stable(data_lines_oe);
    endproperty
    a_stall_oe: assert property (p_stall_oe)
        else $error("drive state moved on an ignored edge");

    property p_deselect;
        load_q && !sel_on ##1 !clock_qualifier_n |=> !data_lines_oe;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("drivers on after a deselect");

    property p_write_tri;
        load_q && sel_on && !write_select_n ##1 !clock_qualifier_n
            |=> !data_lines_oe;
    endproperty
    a_write_tri: assert property (p_write_tri)
        else $error("drivers on in the data cycle of a write");

    property p_read_drive;
        awake && load_q && sel_on && write_select_n
            ##1 !clock_qualifier_n && !output_enable_n
            |=> data_lines_oe || output_enable_n;
    endproperty
    a_read_drive: assert property (p_read_drive)
        else $error("read data not driven one edge after the read");

    property p_adv_desel;
        load_q && !sel_on ##1 !clock_qualifier_n && advance_or_load_n
            ##1 !clock_qualifier_n |=> !data_lines_oe;
    endproperty
    a_adv_desel: assert property (p_adv_desel)
        else $error("advance revived a deselected port");

    property p_sleep_quiet;
        sleep_request [*4] |=> !data_lines_oe;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet)
        else $error("drivers on while asleep");
endmodule : psap_access_port_props

bind psap_access_port psap_access_port_props #(.LANES(LANES)) u_props (
    .clock(clock), .nrst(nrst), .clock_qualifier_n(clock_qualifier_n),
    .chip_select_first_n(chip_select_first_n),
    .chip_select_second(chip_select_second),
    .chip_select_third_n(chip_select_third_n),
    .advance_or_load_n(advance_or_load_n), .write_select_n(write_select_n),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request),
    .data_lines_out(data_lines_out),
    .parity_data_lines_out(parity_data_lines_out),
    .data_lines_oe(data_lines_oe)
);

// [psap_master.sv]
`timescale 1ns/10ps

module psap_master (
    input  wire logic        clock,
    output logic             qual_n,
    output logic [2:0]       sel,
    output logic             ld_n,
    output logic             we_n,
    output logic [3:0]       bw_n,
    output logic             oe_n,
    output logic [9:0]       addr,
    output logic [35:0]      wire_in,
    input  wire logic [35:0] dev_out,
    input  wire logic        dev_oe
);
    logic        wr_type = 1'b0;
    logic        pend    = 1'b0;
    logic        wr_seen = 1'b0;
    logic [35:0] seen_d  = 36'h0;
    logic        wr_now;
    logic [35:0] wdata   = 36'h0;
    logic [35:0] pend_d  = 36'h0;
    logic [35:0] last    = 36'h0;

    initial begin
        qual_n = 1'b1;
        sel    = 3'h0;
        ld_n   = 1'b1;
        we_n   = 1'b1;
        bw_n   = 4'hF;
        oe_n   = 1'b0;
        addr   = 10'h000;
    end

    // Burst keeps its type; selects only count at a load
    assign wr_now = ld_n ? wr_type : (sel == 3'h2 && !we_n);

    always @(posedge clock) begin
        last <= wire_in;
        if (!qual_n) begin
            wr_type <= wr_now;
            wr_seen <= wr_now;
            seen_d  <= wdata;
            pend    <= wr_seen;
            pend_d  <= seen_d;
        end
    end

    // Write data only after the tri-state edge of its write; released
    // lines show the inverse of their last level so nothing stale passes
    assign wire_in = dev_oe ? dev_out : pend ? pend_d : ~last;

    task automatic beat(input logic q, input logic l, input logic [2:0] s,
                        input logic w, input logic [3:0] b, input logic o,
                        input logic [9:0] a, input logic [35:0] d);
        qual_n = q;
        ld_n   = l;
        sel    = s;
        we_n   = w;
        bw_n   = b;
        oe_n   = o;
        addr   = a;
        wdata  = d;
        @(posedge clock);
        #1;
    endtask : beat
endmodule : psap_master

// [tb.sv]
`timescale 1ns/10ps

module tb;
    import psap_pkg::*;

    logic        clock = 1'b0;
    logic        nrst  = 1'b0;
    logic        strap = 1'b1;
    logic        sleep = 1'b0; // Held low outside the sleep
    logic        q_n, ld_n, we_n, oe_n, oe, wbr, fresh;
    logic [2:0]  sel;
    logic [3:0]  bw_n;
    logic [9:0]  addr;
    logic [35:0] win, dout;
    logic [35:0] mem [0:1023];
    logic [36:0] exq [$];
    logic [9:0]  base;
    logic [1:0]  cnt;
    logic        act, wrt;
    int          error_cnt = 0;
    int          n_checks  = 0;

    always #20 clock = ~clock;

    psap_access_port u_dut (
        .clock(clock), .nrst(nrst), .clock_qualifier_n(q_n),
        .chip_select_first_n(sel[2]), .chip_select_second(sel[1]),
        .chip_select_third_n(sel[0]), .advance_or_load_n(ld_n),
        .write_select_n(we_n), .byte_lane_write_n(bw_n),
        .output_enable_n(oe_n), .address(addr), .burst_order_strap(strap),
        .sleep_request(sleep), .data_lines_in(win[31:0]),
        .parity_data_lines_in(win[35:32]), .data_lines_out(dout[31:0]),
        .parity_data_lines_out(dout[35:32]), .data_lines_oe(oe),
        .write_buffer_ready(wbr)
    );

    psap_master u_master (
        .clock(clock), .qual_n(q_n), .sel(sel), .ld_n(ld_n), .we_n(we_n),
        .bw_n(bw_n), .oe_n(oe_n), .addr(addr), .wire_in(win),
        .dev_out(dout), .dev_oe(oe)
    );

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [35:0] rnd36();
        return {4'($urandom), $urandom};
    endfunction : rnd36

    // Model notes the outcome of every qualified beat before driving it
    task automatic op(input logic q, input logic l, input logic [2:0] s,
                      input logic w, input logic [3:0] b,
                      input logic [9:0] a, input logic [35:0] d);
        logic       o;
        logic [9:0] ea;
        o = ($urandom % 5) == 0;
        if (!q) begin
            if (!l) begin
                base = a;
                cnt  = PSAP_BURST_START;
                act  = (s == 3'h2);
                wrt  = !w;
            end else
                cnt = cnt + PSAP_BURST_STEP;
            ea = {base[9:2], strap ? base[1:0] ^ cnt : base[1:0] + cnt};
            for (int i = 0; i < 4; i++) begin
                if (act && wrt && !b[i]) begin
                    mem[ea][8*i+:8] = d[8*i+:8];
                    mem[ea][32+i]   = d[32+i];
                end
            end
            exq.push_back({act && !wrt, mem[ea]});
        end
        u_master.beat(q, l, s, w, b, o, a, d);
    endtask : op

    // Ignored edge with junk on every control
    task automatic stall();
        op(1'b1, 1'($urandom), 3'($urandom), 1'($urandom), 4'($urandom),
           10'($urandom), rnd36());
    endtask : stall

    task automatic burst(input logic w, input logic [9:0] a,
                         input logic [3:0] b);
        for (int k = 0; k < 4; k++) begin
            if ($urandom % 4 == 0)
                stall();
            op(1'b0, k != 0, 3'h2, w, b, a, rnd36());
        end
    endtask : burst

    // Each result is the beat taken one qualified edge earlier
    always @(posedge clock) fresh <= !q_n && nrst;
    always @(negedge clock) begin
        logic [36:0] e;
        if (fresh && exq.size() > 0) begin
            e = exq.pop_front();
            chk({35'h0, oe}, {35'h0, e[36] && !oe_n});
            if (e[36] && !oe_n)
                chk(dout, e[35:0]);
        end
    end

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    initial begin
        #(40 * 5000);
        error_cnt++;
        complete_run();
    end

    initial begin
        void'($urandom(52644));
        // First qualified edge after reset shows the idle pipeline
        exq.push_back(37'h0);
        repeat (8) @(posedge clock);
        #1 nrst = 1'b1;
        repeat (3) stall();
        for (int g = 0; g < 16; g++)
            burst(1'b0, {4'h0, 4'(g), 2'($urandom)}, 4'h0);
        for (int p = 0; p < 2; p++) begin
            op(1'b0, 1'b0, 3'h0, 1'b1, 4'hF, 10'h000, 36'h0);
            strap = p[0]; // Strap moves only while deselected and idle
            repeat (3) stall();
            for (int i = 0; i < 40; i++) begin
                if (i % 4 == 0)
                    burst(1'($urandom), 10'($urandom % 64), 4'($urandom));
                else
                    op(1'b0, 1'b0, 3'h2, 1'($urandom), 4'($urandom),
                       10'($urandom % 64), rnd36());
            end
        end
        for (int j = 0; j < 3; j++) begin
            op(1'b0, 1'b0, 3'h2 ^ (3'h1 << j), 1'($urandom), 4'h0,
               10'($urandom % 64), rnd36());
            op(1'b0, 1'b1, 3'h2, 1'b0, 4'h0, 10'h000, rnd36());
            op(1'b0, 1'b0, 3'h2, 1'b1, 4'hF, 10'(j), 36'h0);
        end
        op(1'b0, 1'b0, 3'h0, 1'b1, 4'hF, 10'h000, 36'h0);
        sleep = 1'b1;
        repeat (6) stall();
        sleep = 1'b0;
        repeat (20) stall();
        for (int r = 0; r < 4; r++)
            burst(1'b1, 10'($urandom % 64), 4'hF);
        op(1'b0, 1'b0, 3'h0, 1'b1, 4'hF, 10'h000, 36'h0);
        op(1'b0, 1'b0, 3'h0, 1'b1, 4'hF, 10'h000, 36'h0);
        chk({35'h0, wbr}, 36'h1);
        complete_run();
    end
endmodule : tb
